// [pcs_core_seq.sv]
// Program counter, stack pointer and status sequencing with stack traffic
`timescale 1ns/100ps
// Function
// - Sixteen registers; 0 to 3 dedicated, 4 to 15 general working registers.
// - Program counter is 20 bits and holds the next instruction address.
// - Program counter advances by instruction length of 2, 4, 6 or 8 bytes.
// - Fetches are word aligned; program counter bit 0 stays zero.
// - Any register write may target the program counter, acting as a branch.
// - Near jump and near subroutine entry clear the upper four counter bits.
// - Far jump and far subroutine entry load all 20 counter bits.
// - Direct counter writes follow operand size; word writes clear upper bits.
// - Near subroutine entry pushes only return address bits 15 to 0.
// - Far subroutine exit reloads 20 counter bits, stack pointer plus four.
// - Near subroutine exit reloads bits 15 to 0, stack pointer plus two.
// - Interrupt entry pushes program counter and status register.
// - Stacked status word carries counter bits 19 to 16 in its top nibble.
// - Interrupt exit restores status and the complete 20-bit counter.
// - Vectors sit at descending addresses from 0FFFEh, no polling.
// - Each vector is a 16-bit handler address in the lowest 64 KB.
// - Linear 1-MB range on 20-bit address and 16-bit data bus.
// - Stack pointer predecrements on push, postincrements on pop, stays even.
// - Status register is 16 bits; register writes reach it only with word operands.
module pcs_core_seq
	import pcs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        cmdValid,
	input  wire pcs_cmd_s    cmd,
	output logic             cmdReady,
	output logic             memValid,
	output pcs_mem_s         memReq,
	input  wire logic        memAck,
	input  wire logic [15:0] memRdata,
	input  wire logic [3:0]  regRdIdx,
	output logic      [19:0] regRdData,
	output logic      [19:0] pcOut,
	output logic      [15:0] srOut,
	output logic      [19:0] spOut
);

	// ==========================================================
	// State
	typedef enum logic {ST_IDLE, ST_ACCESS} pcs_state_e;

	pcs_state_e  state_r, state_nxt;
	pcs_op_e     op_r, op_nxt;
	logic [1:0]  stage_r, stage_nxt;
	logic [19:0] pc_r, pc_nxt;
	logic [19:0] sp_r, sp_nxt;
	logic [15:0] sr_r, sr_nxt;
	logic [19:0] tgt_r, tgt_nxt;
	logic [15:0] tmp_r, tmp_nxt;
	pcs_mem_s    mem_r, mem_nxt;
	logic        memValid_r, memValid_nxt;
	logic [19:0] special_r;
	logic        rdGp_r;

	// ==========================================================
	// Derived values
	logic        cmdTake;
	logic [19:0] retAddr;
	logic [19:0] spDec;
	logic [19:0] spInc2;
	logic [19:0] spInc4;
	logic [19:0] nearTgt;
	logic [19:0] farTgt;
	logic [19:0] sizedData;
	logic [19:0] vecData;
	logic [15:0] stackedSr;
	logic [19:0] gpRdData;
	logic        gpWe;
	logic [19:0] gpWdata;

	assign cmdTake   = cmdValid && state_r == ST_IDLE;
	assign spDec     = pcsAlign(20'(sp_r - WORD_BYTES));
	assign spInc2    = pcsAlign(20'(sp_r + WORD_BYTES));
	assign spInc4    = pcsAlign(20'(sp_r + AWORD_BYTES));
	assign nearTgt   = pcsAlign(cmd.data & LOW_REGION);
	assign farTgt    = pcsAlign(cmd.data);
	// Word operands drop the upper nibble on any register destination
	assign sizedData = cmd.wide ? cmd.data : (cmd.data & LOW_REGION);
	// Handler addresses are only 16 bits wide
	assign vecData   = pcsAlign({4'h0, memRdata});
	// Counter bits 19:16 ride in the reserved top nibble of the status word
	assign stackedSr = {pc_r[19:16], sr_r[SR_PCHI_LSB-1:0]};

	// Return address is the instruction after the entry instruction
	pcs_pc_step u_step (
		.pc      (pc_r),
		.lenCode (cmd.lenCode),
		.pcNext  (retAddr)
	);

	pcs_gp_regs u_gp (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wrEn    (gpWe),
		.wrIdx   (cmd.dst),
		.wrData  (gpWdata),
		.rdIdx   (regRdIdx),
		.rdData  (gpRdData)
	);

	// ==========================================================
	// Next-state logic for command acceptance and stack accesses
	// Stack layout, lowest address on top of stack:
	//   near entry      one word, return address bits 15:0
	//   far entry       high word at SP-2, low word at SP-4
	//   interrupt       counter bits 15:0 at SP-2, status word at SP-4
	//   status word     counter bits 19:16 in the top nibble
	// Pops read the top word first and walk upward, so the far and
	// interrupt exits see the low word or status word before the rest.
	// Only one access is outstanding; stage_r counts finished accesses.
	// The counter changes only when the last access of a sequence is acked,
	// so a stalled sequence never leaves a half-loaded counter.
	always_comb begin
		state_nxt    = state_r;
		op_nxt       = op_r;
		stage_nxt    = stage_r;
		pc_nxt       = pc_r;
		sp_nxt       = sp_r;
		sr_nxt       = sr_r;
		tgt_nxt      = tgt_r;
		tmp_nxt      = tmp_r;
		mem_nxt      = mem_r;
		memValid_nxt = memValid_r;
		gpWe         = 1'b0;
		gpWdata      = sizedData;
		case (state_r)
			ST_IDLE: begin
				// Take a command only while no stack access is pending
				if (cmdTake) begin
					op_nxt    = cmd.op;
					stage_nxt = 2'h0;
					case (cmd.op)
						// Plain sequential advance past the current instruction
						OP_STEP: begin
							pc_nxt = retAddr;
						end
						// Register write; the counter acts as a branch target
						OP_REG_WR: begin
							case (cmd.dst)
								REG_PC: pc_nxt = pcsAlign(sizedData);
								REG_SP: sp_nxt = pcsAlign(sizedData);
								REG_SR: begin
									// Address-word writes to status are dropped
									if (!cmd.wide) begin
										sr_nxt = cmd.data[15:0] & SR_LIVE;
									end
								end
								REG_CG: begin
									// Constant source only, writes ignored
								end
								default: gpWe = 1'b1;
							endcase
						end
						// Near jump stays in the lowest 64 KB
						OP_JUMP_NEAR: begin
							pc_nxt = nearTgt;
						end
						// Far jump reaches the whole 1-MB range
						OP_JUMP_FAR: begin
							pc_nxt = farTgt;
						end
						// One push, the jump waits for its ack
						OP_SUB_ENTRY_NEAR: begin
							sp_nxt       = spDec;
							tgt_nxt      = nearTgt;
							mem_nxt      = pcsReq(spDec, retAddr[15:0], 1'b1);
							memValid_nxt = 1'b1;
							state_nxt    = ST_ACCESS;
						end
						OP_SUB_ENTRY_FAR: begin
							// High word first so the low word ends on top
							sp_nxt       = spDec;
							tgt_nxt      = farTgt;
							tmp_nxt      = retAddr[15:0];
							mem_nxt      = pcsReq(spDec, {12'h000, retAddr[19:16]}, 1'b1);
							memValid_nxt = 1'b1;
							state_nxt    = ST_ACCESS;
						end
						// Every pop starts with the top-of-stack word
						OP_SUB_EXIT_NEAR, OP_SUB_EXIT_FAR, OP_INTERRUPT_EXIT: begin
							mem_nxt      = pcsReq(sp_r, 16'h0000, 1'b0);
							memValid_nxt = 1'b1;
							state_nxt    = ST_ACCESS;
						end
						OP_IRQ: begin
							// Current counter is already the resume address
							sp_nxt       = spDec;
							tmp_nxt      = stackedSr;
							tgt_nxt      = pcsVecAddr(cmd.vec);
							mem_nxt      = pcsReq(spDec, pc_r[15:0], 1'b1);
							memValid_nxt = 1'b1;
							state_nxt    = ST_ACCESS;
						end
						default: begin
							// Unknown command codes are consumed with no effect
						end
					endcase
				end
			end
			ST_ACCESS: begin
				// Nothing moves until the memory acknowledges
				if (memAck) begin
					memValid_nxt = 1'b0;
					stage_nxt    = 2'(stage_r + 2'h1);
					state_nxt    = ST_IDLE;
					case (op_r)
						// Jump only after the return address is stored
						OP_SUB_ENTRY_NEAR: begin
							pc_nxt = tgt_r;
						end
						// Second push of the low word, then the jump
						OP_SUB_ENTRY_FAR: begin
							if (stage_r == 2'h0) begin
								sp_nxt       = spDec;
								mem_nxt      = pcsReq(spDec, tmp_r, 1'b1);
								memValid_nxt = 1'b1;
								state_nxt    = ST_ACCESS;
							end else begin
								pc_nxt = tgt_r;
							end
						end
						// Single pop; the top nibble of the counter is cleared
						OP_SUB_EXIT_NEAR: begin
							pc_nxt = vecData;
							sp_nxt = spInc2;
						end
						// Low word first, then the high word with bits 19:16
						OP_SUB_EXIT_FAR: begin
							if (stage_r == 2'h0) begin
								tmp_nxt      = memRdata;
								mem_nxt      = pcsReq(spInc2, 16'h0000, 1'b0);
								memValid_nxt = 1'b1;
								state_nxt    = ST_ACCESS;
							end else begin
								pc_nxt = pcsAlign({memRdata[3:0], tmp_r});
								sp_nxt = spInc4;
							end
						end
						// Two pushes, then the vector fetch
						OP_IRQ: begin
							if (stage_r == 2'h0) begin
								sp_nxt       = spDec;
								mem_nxt      = pcsReq(spDec, tmp_r, 1'b1);
								memValid_nxt = 1'b1;
								state_nxt    = ST_ACCESS;
							end else if (stage_r == 2'h1) begin
								mem_nxt      = pcsReq(tgt_r, 16'h0000, 1'b0);
								memValid_nxt = 1'b1;
								state_nxt    = ST_ACCESS;
							end else begin
								pc_nxt = vecData;
							end
						end
						// Status word first, then counter bits 15:0
						OP_INTERRUPT_EXIT: begin
							if (stage_r == 2'h0) begin
								sr_nxt       = memRdata & SR_LIVE;
								tmp_nxt      = {12'h000, memRdata[15:12]};
								mem_nxt      = pcsReq(spInc2, 16'h0000, 1'b0);
								memValid_nxt = 1'b1;
								state_nxt    = ST_ACCESS;
							end else begin
								pc_nxt = pcsAlign({tmp_r[3:0], memRdata});
								sp_nxt = spInc4;
							end
						end
						default: begin
							// Nothing pending for other commands
						end
					endcase
				end
			end
			// Illegal state falls back to idle with the bus released
			default: begin
				state_nxt    = ST_IDLE;
				memValid_nxt = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Sequencer registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= ST_IDLE;
			op_r       <= OP_STEP;
			stage_r    <= 2'h0;
			pc_r       <= PC_RESET;
			sp_r       <= SP_RESET;
			sr_r       <= SR_RESET;
			tgt_r      <= 20'h00000;
			tmp_r      <= 16'h0000;
			mem_r      <= '0;
			memValid_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			op_r       <= op_nxt;
			stage_r    <= stage_nxt;
			pc_r       <= pc_nxt;
			sp_r       <= sp_nxt;
			sr_r       <= sr_nxt;
			tgt_r      <= tgt_nxt;
			tmp_r      <= tmp_nxt;
			mem_r      <= mem_nxt;
			memValid_r <= memValid_nxt;
		end
	end

	// ==========================================================
	// Register read port, dedicated registers held in a flop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			special_r <= 20'h00000;
			rdGp_r    <= 1'b0;
		end else begin
			// Working registers answer from their own registered port
			rdGp_r <= regRdIdx >= REG_GP_BASE;
			case (regRdIdx)
				REG_PC:  special_r <= pc_r;
				REG_SP:  special_r <= sp_r;
				REG_SR:  special_r <= {4'h0, sr_r};
				default: special_r <= 20'h00000;
			endcase
		end
	end

	// ==========================================================
	// Outputs; one access at a time keeps the bus protocol trivial
	assign cmdReady  = state_r == ST_IDLE;
	assign memValid  = memValid_r;
	assign memReq    = mem_r;
	assign regRdData = rdGp_r ? gpRdData : special_r;
	assign pcOut     = pc_r;
	assign srOut     = sr_r;
	assign spOut     = sp_r;

endmodule

// [pcs_pkg.sv]
// Shared constants, types and helpers of the program-counter and stack sequencer
package pcs_pkg;

	// ==========================================================
	// Widths and register numbers
	localparam int          ADDR_W      = 20;
	localparam int          DATA_W      = 16;
	localparam int          NUM_REGS    = 16;
	localparam int          NUM_GP      = 12;
	localparam logic [3:0]  REG_PC      = 4'h0;
	localparam logic [3:0]  REG_SP      = 4'h1;
	localparam logic [3:0]  REG_SR      = 4'h2;
	localparam logic [3:0]  REG_CG      = 4'h3;
	localparam logic [3:0]  REG_GP_BASE = 4'h4;

	// ==========================================================
	// Reset values, masks and address constants
	localparam logic [19:0] PC_RESET    = 20'h00000;
	localparam logic [19:0] SP_RESET    = 20'h00000;
	localparam logic [15:0] SR_RESET    = 16'h0000;
	localparam logic [15:0] SR_LIVE     = 16'h0FFF;
	localparam int          SR_PCHI_LSB = 12;
	localparam logic [19:0] LOW_REGION  = 20'h0FFFF;
	localparam logic [19:0] EVEN_MASK   = 20'hFFFFE;
	localparam logic [19:0] WORD_BYTES  = 20'h00002;
	localparam logic [19:0] AWORD_BYTES = 20'h00004;
	localparam logic [19:0] VEC_TOP     = 20'h0FFFE;

	// ==========================================================
	// Commands and bus payloads
	typedef enum logic [3:0] {
		OP_STEP, OP_REG_WR, OP_JUMP_NEAR, OP_JUMP_FAR,
		OP_SUB_ENTRY_NEAR, OP_SUB_ENTRY_FAR, OP_SUB_EXIT_NEAR,
		OP_SUB_EXIT_FAR, OP_IRQ, OP_INTERRUPT_EXIT
	} pcs_op_e;

	typedef struct packed {
		pcs_op_e     op;
		logic [1:0]  lenCode;   // Bytes = 2 * (lenCode + 1)
		logic        wide;      // 1: 20-bit operand, 0: word operand
		logic [3:0]  dst;
		logic [19:0] data;      // Target address or register value
		logic [4:0]  vec;
	} pcs_cmd_s;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic        write;
	} pcs_mem_s;

	// ==========================================================
	// Helpers
	function automatic logic [19:0] pcsAlign(input logic [19:0] a);
		return a & EVEN_MASK;
	endfunction

	function automatic pcs_mem_s pcsReq(input logic [19:0] a, input logic [15:0] d,
		input logic w);
		pcs_mem_s r;
		r.addr  = pcsAlign(a);
		r.wdata = d;
		r.write = w;
		return r;
	endfunction

	function automatic logic [19:0] pcsVecAddr(input logic [4:0] v);
		return 20'(VEC_TOP - {14'h0000, v, 1'b0});
	endfunction

endpackage

// [pcs_gp_regs.sv]
// Working register storage for registers 4 to 15, registered read port
`timescale 1ns/100ps
module pcs_gp_regs
	import pcs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        wrEn,
	input  wire logic [3:0]  wrIdx,
	input  wire logic [19:0] wrData,
	input  wire logic [3:0]  rdIdx,
	output logic      [19:0] rdData
);

	// ==========================================================
	// Storage
	logic [19:0] mem [NUM_GP];
	logic [3:0]  wrOff;
	logic [3:0]  rdOff;

	// Register number minus the four dedicated ones
	assign wrOff = 4'(wrIdx - REG_GP_BASE);
	assign rdOff = 4'(rdIdx - REG_GP_BASE);

	// Array has no reset to stay a plain memory
	always_ff @(posedge ref_clk) begin
		if (wrEn && wrIdx >= REG_GP_BASE) begin
			mem[wrOff] <= wrData;
		end
	end

	// Read data leaves from a register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdData <= 20'h00000;
		end else if (rdIdx >= REG_GP_BASE) begin
			rdData <= mem[rdOff];
		end
	end

endmodule

// [pcs_pc_step.sv]
// Sequential program counter advance by instruction length
`timescale 1ns/100ps
module pcs_pc_step
	import pcs_pkg::*;
(
	input  wire logic [19:0] pc,
	input  wire logic [1:0]  lenCode,
	output logic      [19:0] pcNext
);

	// ==========================================================
	// Length in bytes: 2, 4, 6 or 8
	logic [19:0] lenBytes;

	assign lenBytes = 20'({17'h00000, lenCode, 1'b0} + WORD_BYTES);
	// Wraps inside the 1-MB range, keeps word alignment
	assign pcNext   = pcsAlign(20'(pc + lenBytes));

endmodule

// [pcs_checker.sv]
// Assertion checker for the program-counter and stack sequencer ports
`timescale 1ns/100ps
module pcs_checker
	import pcs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        cmdValid,
	input  wire pcs_cmd_s    cmd,
	input  wire logic        cmdReady,
	input  wire logic        memValid,
	input  wire pcs_mem_s    memReq,
	input  wire logic        memAck,
	input  wire logic [19:0] pcOut,
	input  wire logic [15:0] srOut,
	input  wire logic [19:0] spOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// =========================================
	// Command take, shared by the step, jump, push and pop checks
	wire logic take = cmdValid && cmdReady;

	sequence take_s(pcs_op_e o);
		take && cmd.op == o;
	endsequence

	// =========================================
	// Register and bus relations
	pc_even_a: assert property (pcOut[0] == 1'b0)
		else $error("counter odd");
	sp_even_a: assert property (spOut[0] == 1'b0)
		else $error("stack pointer odd");
	sr_top_a: assert property (srOut[15:12] == 4'h0)
		else $error("status top bits set");
	busy_ready_a: assert property (memValid |-> !cmdReady)
		else $error("ready while stacking");
	req_hold_a: assert property (memValid && !memAck |=> memValid && $stable(memReq))
		else $error("request moved before ack");
	step_len_a: assert property (take_s(OP_STEP) |=>
		pcOut == 20'($past(pcOut) + 20'($past(cmd.lenCode)) * 2 + 2))
		else $error("step length wrong");
	jump_near_a: assert property (take_s(OP_JUMP_NEAR) |=>
		pcOut == {4'h0, $past(cmd.data[15:1]), 1'b0}) else $error("near jump wrong");
	jump_far_a: assert property (take_s(OP_JUMP_FAR) |=>
		pcOut == {$past(cmd.data[19:1]), 1'b0}) else $error("far jump wrong");
	near_push_a: assert property (take_s(OP_SUB_ENTRY_NEAR) |=> memValid
		&& memReq.write && memReq.addr == 20'($past(spOut) - 20'h00002))
		else $error("near push address wrong");
	near_pop_a: assert property (take_s(OP_SUB_EXIT_NEAR) |=> memValid
		&& !memReq.write && memReq.addr == $past(spOut)) else $error("near pop wrong");
endmodule

bind pcs_core_seq pcs_checker chk (.ref_clk(ref_clk), .resetn(resetn),
	.cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .memValid(memValid),
	.memReq(memReq), .memAck(memAck), .pcOut(pcOut), .srOut(srOut), .spOut(spOut));

// [pcs_mem_model.sv]
// Program and data memory model on the 20-bit address, 16-bit data bus
`timescale 1ns/100ps
module pcs_mem_model
	import pcs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        memValid,
	input  wire pcs_mem_s    memReq,
	input  wire logic        slow,
	output logic             memAck,
	output logic      [15:0] memRdata
);
	logic [15:0] mem [logic [19:0]];
	logic [1:0]  wait_r;
	logic [15:0] last_r;

	// Preload, used for vector words
	function automatic void put(input logic [19:0] a, input logic [15:0] d);
		mem[a] = d;
	endfunction

	// Ack at once, or two cycles late when slow
	assign memAck = memValid && wait_r == 2'h0;

	// Read data only on ack; otherwise inverted so stale data never passes
	always_comb begin
		memRdata = ~last_r;
		if (memAck && mem.exists(memReq.addr))
			memRdata = mem[memReq.addr];
		else if (memAck)
			memRdata = 16'h0000;
	end

	// Latency counter and linear word store
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wait_r <= 2'h0;
			last_r <= 16'h0000;
		end else begin
			wait_r <= (memAck || !memValid) ? (slow ? 2'h2 : 2'h0) : wait_r - 2'h1;
			if (memAck)
				last_r <= memRdata;
			if (memAck && memReq.write)
				mem[memReq.addr] = memReq.wdata;
		end
	end
endmodule

// [tb_top.sv]
// Self-checking bench for the program-counter and stack sequencer
`timescale 1ns/100ps
module tb_top
	import pcs_pkg::*;
;
	logic        ref_clk, resetn, cmdValid, cmdReady, memValid, memAck, slow;
	pcs_cmd_s    cmd;
	pcs_mem_s    memReq;
	logic [15:0] memRdata, srOut, sr;
	logic [3:0]  regRdIdx;
	logic [19:0] regRdData, pcOut, spOut, pc, sp, r;
	logic [35:0] expQ [$];
	logic [31:0] seed = 32'h000157F7;
	int          failures = 0;
	int          n_compared = 0;
	int          cycles = 0;

	pcs_core_seq dut (.ref_clk(ref_clk), .resetn(resetn), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .memValid(memValid), .memReq(memReq), .memAck(memAck),
		.memRdata(memRdata), .regRdIdx(regRdIdx), .regRdData(regRdData),
		.pcOut(pcOut), .srOut(srOut), .spOut(spOut));
	pcs_mem_model mdl (.ref_clk(ref_clk), .resetn(resetn), .memValid(memValid),
		.memReq(memReq), .slow(slow), .memAck(memAck), .memRdata(memRdata));

	// =========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One command, valid for one clock, then run to completion and checked
	task automatic issue(input pcs_op_e op, input logic [1:0] len, input logic w,
		input logic [3:0] d, input logic [19:0] v, input logic [4:0] vec);
		int n;
		n = 0;
		cmdValid <= 1'b1;
		cmd <= '{op, len, w, d, v, vec};
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		do @(negedge ref_clk); while (!cmdReady && n++ < 60);
		chk({pcOut, srOut}, {pc, sr});
		chk(36'(spOut), 36'(sp));
		@(posedge ref_clk);
	endtask

	// =========================================
	// Clock, hang limit and write monitor
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			print_verdict();
		end
	end

	// Each finished stack write takes the oldest note
	always @(negedge ref_clk)
		if (resetn && memValid && memAck && memReq.write)
			chk({memReq.addr, memReq.wdata}, expQ.size() ? expQ.pop_front() : '1);

	// =========================================
	// Main sequence
	initial begin
		resetn = 1'b0;
		cmdValid = 1'b0;
		cmd = '0;
		regRdIdx = 4'h7;
		slow = 1'b0;
		pc = 20'h00000;
		sp = 20'h00000;
		sr = 16'h0000;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		// Every instruction length
		for (int i = 0; i < 4; i++) begin
			pc = pc + 20'(2 * (i + 1));
			issue(OP_STEP, 2'(i), 1'b0, 4'h0, 20'h00000, 5'h00);
		end
		// Random counter writes, word then full size
		for (int i = 0; i < 6; i++) begin
			r = 20'(rnd()) & EVEN_MASK;
			pc = i[0] ? r : {4'h0, r[15:0]};
			issue(OP_REG_WR, 2'h0, i[0], REG_PC, r, 5'h00);
		end
		sp = 20'h20100;
		issue(OP_REG_WR, 2'h0, 1'b1, REG_SP, sp, 5'h00);
		pc = 20'hABCDE;
		issue(OP_JUMP_FAR, 2'h0, 1'b1, 4'h0, pc, 5'h00);
		// Far call and return with a slow memory
		slow <= 1'b1;
		r = pc + 20'h00004;
		expQ.push_back({sp - 20'h00002, 12'h000, r[19:16]});
		expQ.push_back({sp - 20'h00004, r[15:0]});
		sp = sp - 20'h00004;
		pc = 20'h30000;
		issue(OP_SUB_ENTRY_FAR, 2'h1, 1'b1, 4'h0, pc, 5'h00);
		sp = sp + 20'h00004;
		pc = r;
		issue(OP_SUB_EXIT_FAR, 2'h0, 1'b1, 4'h0, 20'h00000, 5'h00);
		// Near jump, call and return drop the top bits
		slow <= 1'b0;
		pc = 20'h0A5A4;
		issue(OP_JUMP_NEAR, 2'h0, 1'b0, 4'h0, 20'h5A5A4, 5'h00);
		r = pc + 20'h00002;
		expQ.push_back({sp - 20'h00002, r[15:0]});
		sp = sp - 20'h00002;
		pc = 20'h0F002;
		issue(OP_SUB_ENTRY_NEAR, 2'h0, 1'b0, 4'h0, 20'h7F002, 5'h00);
		sp = sp + 20'h00002;
		pc = r;
		issue(OP_SUB_EXIT_NEAR, 2'h0, 1'b0, 4'h0, 20'h00000, 5'h00);
		// Interrupt entry through vector 3, then exit
		sr = 16'h0123;
		issue(OP_REG_WR, 2'h0, 1'b0, REG_SR, 20'h00123, 5'h00);
		issue(OP_REG_WR, 2'h0, 1'b1, REG_SR, 20'hFFFFF, 5'h00);
		pc = 20'h5432A;
		issue(OP_REG_WR, 2'h0, 1'b1, REG_PC, pc, 5'h00);
		mdl.put(20'h0FFF8, 16'h4C00);
		slow <= 1'b1;
		expQ.push_back({sp - 20'h00002, pc[15:0]});
		expQ.push_back({sp - 20'h00004, pc[19:16], sr[11:0]});
		r = pc;
		sp = sp - 20'h00004;
		pc = 20'h04C00;
		issue(OP_IRQ, 2'h0, 1'b0, 4'h0, 20'h00000, 5'h03);
		sr = 16'h0000;
		issue(OP_REG_WR, 2'h0, 1'b0, REG_SR, 20'h00000, 5'h00);
		sr = 16'h0123;
		sp = sp + 20'h00004;
		pc = r;
		issue(OP_INTERRUPT_EXIT, 2'h0, 1'b0, 4'h0, 20'h00000, 5'h00);
		// Working register readback
		r = 20'(rnd());
		issue(OP_REG_WR, 2'h0, 1'b1, 4'h7, r, 5'h00);
		@(negedge ref_clk);
		chk(36'(regRdData), 36'(r));
		chk(36'(expQ.size()), 36'h0);
		print_verdict();
	end
endmodule
